/* logic/psc_pkg.sv */
`default_nettype none
package psc_pkg;

  // controller clock
  localparam int CLK_MHZ = 40;

  // core frequency codes, as firmware writes them
  localparam logic [1:0] FREQ_12M = 2'h0;
  localparam logic [1:0] FREQ_24M = 2'h1;
  localparam logic [1:0] FREQ_48M = 2'h2;
  localparam logic [1:0] FREQ_RESET = FREQ_48M;

  // pll multiplier from the 12 MHz reference for each core frequency
  localparam logic [2:0] MULT_12M = 3'h1;
  localparam logic [2:0] MULT_24M = 3'h2;
  localparam logic [2:0] MULT_48M = 3'h4;

  // reference crystal frequency
  localparam int XTAL_MHZ = 12;

  // number of peripheral interface modules and of wake lines
  localparam int PERIPH_COUNT = 9;
  localparam int WAKE_COUNT = 7;
  localparam logic [PERIPH_COUNT-1:0] PERIPH_POWER_RESET = 9'h000;

  // settle times in ns, and cycle counts derived from them (least times round up)
  localparam int OSC_SETTLE_NS = 100000;
  localparam int PLL_SETTLE_NS = 50000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // power state machine, gray coded along entry and wake path except pll wait to run
  typedef enum logic [2:0] {
    PSC_RUN = 3'h0,
    PSC_GATE = 3'h1,
    PSC_STANDBY = 3'h3,
    PSC_OSC_WAIT = 3'h2,
    PSC_PLL_WAIT = 3'h6
  } psc_state_t;

endpackage : psc_pkg
`default_nettype wire

/* logic/psc_wake_sense.sv */
`timescale 1ns/10ps
`default_nettype none
// level-compare wake detector: pins pass two flops, a snapshot is taken on
// entry, and any difference afterwards is a toggle. comparing levels instead
// of clocking edges means a toggle made while clocks were slowed is not lost.
module psc_wake_sense (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic armPulse,
  input wire logic armed,
  // pins from outside
  input wire logic [psc_pkg::WAKE_COUNT-1:0] wakePins,
  // result
  output logic wakeHit
);

  logic [psc_pkg::WAKE_COUNT-1:0] syncA_reg;
  logic [psc_pkg::WAKE_COUNT-1:0] syncB_reg;
  logic [psc_pkg::WAKE_COUNT-1:0] snap_reg;
  logic hit_reg;
  wire logic differ;

  assign differ = |(syncB_reg ^ snap_reg);
  assign wakeHit = hit_reg;

  // two-flop synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_reg <= 7'h00;
      syncB_reg <= 7'h00;
    end
    else
    begin
      syncA_reg <= wakePins;
      syncB_reg <= syncA_reg;
    end
  end

  // snapshot at arming, then flag any line that has moved since
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      snap_reg <= 7'h00;
      hit_reg <= 1'b0;
    end
    else
    begin
      if (armPulse)
        snap_reg <= syncB_reg;
      hit_reg <= armed & ~armPulse & differ;
    end
  end

endmodule : psc_wake_sense
`default_nettype wire

/* logic/psc_clock_power.sv */
`timescale 1ns/10ps
`default_nettype none
module psc_clock_power (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // firmware control
  input wire logic [1:0] freqSel,
  input wire logic freqApply,
  input wire logic standbyReq,
  input wire logic [psc_pkg::PERIPH_COUNT-1:0] periphInUse,
  // analog cell status
  input wire logic oscReady,
  input wire logic pllLock,
  // wake pins
  input wire logic usbAPlus,
  input wire logic usbAMinus,
  input wire logic usbBPlus,
  input wire logic usbBMinus,
  input wire logic slave_port_a_select_n,
  input wire logic slave_port_b_select_n,
  input wire logic serial_ring_indicator_n,
  // oscillator and pll control
  output logic crystalOscEnable,
  output logic pllEnable,
  output logic [2:0] pllMult,
  // core clock and power
  output logic coreClkRun,
  output logic [1:0] coreFreq,
  output logic [psc_pkg::PERIPH_COUNT-1:0] periphPowerEn,
  output logic systemPowerEn,
  // status
  output logic inStandby,
  output logic wakeEvent
);

  psc_pkg::psc_state_t state_reg;
  psc_pkg::psc_state_t state_next;
  logic [psc_pkg::CNT_W-1:0] cnt_reg;
  logic [psc_pkg::CNT_W-1:0] cnt_next;
  logic [1:0] freq_reg;
  logic [2:0] mult_reg;
  logic osc_reg;
  logic pll_reg;
  logic clkRun_reg;
  logic sysPwr_reg;
  logic standby_reg;
  logic wakeEv_reg;
  logic [psc_pkg::PERIPH_COUNT-1:0] pwr_reg;
  logic oscSyncA_reg;
  logic oscSyncB_reg;
  logic lockSyncA_reg;
  logic lockSyncB_reg;
  wire logic wakeHit;
  wire logic armPulse;
  wire logic armed;
  wire logic freqValid;
  wire logic freqChange;
  wire logic cntDone;
  wire logic [psc_pkg::WAKE_COUNT-1:0] wakePins;

  // map a frequency code to its pll multiplier of the 12 MHz reference
  function automatic logic [2:0] freq_to_mult(input logic [1:0] code);
    case (code)
      psc_pkg::FREQ_12M: freq_to_mult = psc_pkg::MULT_12M;
      psc_pkg::FREQ_24M: freq_to_mult = psc_pkg::MULT_24M;
      default: freq_to_mult = psc_pkg::MULT_48M;
    endcase
  endfunction : freq_to_mult

  // selects and ring are active low but only toggles matter, so polarity is moot
  assign wakePins = {usbAPlus, usbAMinus, usbBPlus, usbBMinus,
                     slave_port_a_select_n, slave_port_b_select_n,
                     serial_ring_indicator_n};

  // only the three documented codes are taken; code 3 is ignored
  assign freqValid = (freqSel == psc_pkg::FREQ_12M) | (freqSel == psc_pkg::FREQ_24M)
                     | (freqSel == psc_pkg::FREQ_48M);
  // standby request wins: a frequency asked for in the same cycle is dropped
  assign freqChange = freqApply & freqValid & ~standbyReq
                      & (state_reg == psc_pkg::PSC_RUN);
  assign armPulse = (state_reg == psc_pkg::PSC_GATE);
  assign armed = (state_reg == psc_pkg::PSC_STANDBY);
  assign cntDone = (cnt_reg == '0);

  psc_wake_sense u_wake (
    .sys_clk(sys_clk),
    .rst(rst),
    .armPulse(armPulse),
    .armed(armed),
    .wakePins(wakePins),
    .wakeHit(wakeHit)
  );

  // analog status comes from another domain: two flops each
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      oscSyncA_reg <= 1'b0;
      oscSyncB_reg <= 1'b0;
      lockSyncA_reg <= 1'b0;
      lockSyncB_reg <= 1'b0;
    end
    else
    begin
      oscSyncA_reg <= oscReady;
      oscSyncB_reg <= oscSyncA_reg;
      lockSyncA_reg <= pllLock;
      lockSyncB_reg <= lockSyncA_reg;
    end
  end

  // sequencing: standby entry, wake restart, and pll relock on a new frequency
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cntDone ? cnt_reg : cnt_reg - 12'h001;
    case (state_reg)
      psc_pkg::PSC_RUN:
      begin
        if (standbyReq)
          state_next = psc_pkg::PSC_GATE;
        else if (freqChange)
        begin
          // core clock held off while the pll retunes
          state_next = psc_pkg::PSC_PLL_WAIT;
          cnt_next = psc_pkg::CNT_W'(psc_pkg::PLL_SETTLE_CYC);
        end
      end
      psc_pkg::PSC_GATE:
        state_next = psc_pkg::PSC_STANDBY;
      psc_pkg::PSC_STANDBY:
      begin
        if (wakeHit)
        begin
          state_next = psc_pkg::PSC_OSC_WAIT;
          cnt_next = psc_pkg::CNT_W'(psc_pkg::OSC_SETTLE_CYC);
        end
      end
      psc_pkg::PSC_OSC_WAIT:
      begin
        if (cntDone && oscSyncB_reg)
        begin
          state_next = psc_pkg::PSC_PLL_WAIT;
          cnt_next = psc_pkg::CNT_W'(psc_pkg::PLL_SETTLE_CYC);
        end
      end
      psc_pkg::PSC_PLL_WAIT:
      begin
        if (cntDone && lockSyncB_reg)
          state_next = psc_pkg::PSC_RUN;
      end
      default:
        state_next = psc_pkg::PSC_RUN;
    endcase
  end

  // state and settle counter; the 48 MHz start-up takes the same oscillator and pll wait as a wake
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= psc_pkg::PSC_OSC_WAIT;
      cnt_reg <= psc_pkg::CNT_W'(psc_pkg::OSC_SETTLE_CYC);
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // frequency selection held until firmware applies a new valid one
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      freq_reg <= psc_pkg::FREQ_RESET;
      mult_reg <= psc_pkg::MULT_48M;
    end
    else if (freqChange)
    begin
      freq_reg <= freqSel;
      mult_reg <= freq_to_mult(freqSel);
    end
  end

  // clock and power enables follow the next state so outputs are flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_reg <= 1'b1;
      pll_reg <= 1'b0;
      clkRun_reg <= 1'b0;
      sysPwr_reg <= 1'b1;
      standby_reg <= 1'b0;
      wakeEv_reg <= 1'b0;
      pwr_reg <= psc_pkg::PERIPH_POWER_RESET;
    end
    else
    begin
      osc_reg <= (state_next != psc_pkg::PSC_STANDBY)
                 & (state_next != psc_pkg::PSC_GATE);
      pll_reg <= (state_next == psc_pkg::PSC_RUN)
                 | (state_next == psc_pkg::PSC_PLL_WAIT);
      clkRun_reg <= (state_next == psc_pkg::PSC_RUN);
      sysPwr_reg <= (state_next != psc_pkg::PSC_STANDBY)
                    & (state_next != psc_pkg::PSC_GATE);
      standby_reg <= (state_next == psc_pkg::PSC_STANDBY);
      wakeEv_reg <= (state_reg == psc_pkg::PSC_STANDBY) & wakeHit;
      // unused modules always dark; everything dark outside run
      pwr_reg <= (state_next == psc_pkg::PSC_RUN) ? periphInUse
                 : psc_pkg::PERIPH_POWER_RESET;
    end
  end

  assign crystalOscEnable = osc_reg;
  assign pllEnable = pll_reg;
  assign pllMult = mult_reg;
  assign coreClkRun = clkRun_reg;
  assign coreFreq = freq_reg;
  assign periphPowerEn = pwr_reg;
  assign systemPowerEn = sysPwr_reg;
  assign inStandby = standby_reg;
  assign wakeEvent = wakeEv_reg;

endmodule : psc_clock_power
`default_nettype wire

/* dv/psc_clock_power_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module psc_chk_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // firmware side
  input wire logic [1:0] freqSel,
  input wire logic freqApply,
  input wire logic standbyReq,
  input wire logic [8:0] periphInUse,
  // power outputs
  input wire logic crystalOscEnable,
  input wire logic pllEnable,
  input wire logic [2:0] pllMult,
  input wire logic coreClkRun,
  input wire logic [1:0] coreFreq,
  input wire logic [8:0] periphPowerEn,
  input wire logic systemPowerEn,
  input wire logic inStandby,
  input wire logic wakeEvent
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [12:0] waitCnt_reg;
  // cycles since reset or wake, saturating so a long run never wraps
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst) waitCnt_reg <= '0;
    else if (wakeEvent) waitCnt_reg <= '0;
    else if (waitCnt_reg != 13'h1fff) waitCnt_reg <= waitCnt_reg + 13'h0001;
  end
  sequence s_enter;
    coreClkRun && standbyReq;
  endsequence
  sequence s_take;
    coreClkRun && freqApply && !standbyReq;
  endsequence
  // standby entry, then all clocks and power off
  a_standby_gate: assert property (s_enter |=> !coreClkRun && !crystalOscEnable && !systemPowerEn ##1 inStandby) else $error("standby entry wrong");
  a_standby_off: assert property (inStandby |-> !coreClkRun && !pllEnable && !crystalOscEnable && !systemPowerEn && periphPowerEn == 9'h000) else $error("power on in standby");
  a_periph_follow: assert property (coreClkRun && !standbyReq && !freqApply |=> periphPowerEn == $past(periphInUse)) else $error("periph power wrong");
  a_freq_take: assert property (s_take ##0 freqSel != 2'h3 |=> coreFreq == $past(freqSel) && !coreClkRun) else $error("freq not applied");
  a_freq_bad: assert property (s_take ##0 freqSel == 2'h3 |=> $stable(coreFreq)) else $error("bad code applied");
  a_standby_wins: assert property (s_enter |=> $stable(coreFreq) && $stable(pllMult)) else $error("freq taken with standby");
  a_mult_map: assert property (pllMult == (coreFreq == psc_pkg::FREQ_12M ? psc_pkg::MULT_12M : coreFreq == psc_pkg::FREQ_24M ? psc_pkg::MULT_24M : psc_pkg::MULT_48M)) else $error("pll multiplier wrong");
  a_wake_exit: assert property (wakeEvent |-> $past(inStandby) && !inStandby && crystalOscEnable && systemPowerEn ##1 !wakeEvent) else $error("wake exit wrong");
  a_osc_settle: assert property ($rose(pllEnable) |-> waitCnt_reg >= psc_pkg::OSC_SETTLE_CYC - 2) else $error("pll started early");
endmodule : psc_chk_assertions
bind psc_clock_power psc_chk_assertions chk (.*);
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] freqSel = 2'h2;
  logic freqApply = 1'b0;
  logic standbyReq = 1'b0;
  logic [8:0] periphInUse = 9'h000;
  logic oscReady = 1'b1;
  logic pllLock = 1'b1;
  logic [6:0] wk = 7'h70; // usb lines idle low, selects and ring idle high
  logic crystalOscEnable, pllEnable, coreClkRun, systemPowerEn, inStandby, wakeEvent;
  logic [2:0] pllMult;
  logic [1:0] coreFreq;
  logic [8:0] periphPowerEn;
  int err_total = 0;
  int n_tests = 0;
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  psc_clock_power uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .freqSel(freqSel),
    .freqApply(freqApply),
    .standbyReq(standbyReq),
    .periphInUse(periphInUse),
    .oscReady(oscReady),
    .pllLock(pllLock),
    .usbAPlus(wk[0]),
    .usbAMinus(wk[1]),
    .usbBPlus(wk[2]),
    .usbBMinus(wk[3]),
    .slave_port_a_select_n(wk[4]),
    .slave_port_b_select_n(wk[5]),
    .serial_ring_indicator_n(wk[6]),
    .crystalOscEnable(crystalOscEnable),
    .pllEnable(pllEnable),
    .pllMult(pllMult),
    .coreClkRun(coreClkRun),
    .coreFreq(coreFreq),
    .periphPowerEn(periphPowerEn),
    .systemPowerEn(systemPowerEn),
    .inStandby(inStandby),
    .wakeEvent(wakeEvent)
  );
  // inputs move 2 ns after the edge so no race with the design
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("tests=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // bounded wait for the core clock; a hang ends the run
  task automatic wait_run(output int n);
    n = 0;
    while (coreClkRun !== 1'b1 && n < 7000)
    begin
      step(1);
      n++;
    end
    if (n >= 7000)
    begin
      chk(16'h0000, 16'h0001);
      end_sim();
    end
  endtask : wait_run
  task automatic t_reset;
    int n;
    chk({coreFreq, pllMult, coreClkRun, inStandby, systemPowerEn}, {psc_pkg::FREQ_48M, psc_pkg::MULT_48M, 3'b001});
    rst = 1'b0;
    wait_run(n);
    chk(n >= psc_pkg::OSC_SETTLE_CYC + psc_pkg::PLL_SETTLE_CYC, 1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_freq;
    int n;
    logic [2:0] mt [3] = '{psc_pkg::MULT_12M, psc_pkg::MULT_24M, psc_pkg::MULT_48M};
    for (int i = 0; i < 4; i++)
    begin
      freqSel = i[1:0];
      freqApply = 1'b1;
      pllLock = (i != 0); // first change: lock comes late, core must wait for it
      step(1);
      freqApply = 1'b0;
      step(1);
      if (i == 3) chk({coreFreq, coreClkRun}, {psc_pkg::FREQ_48M, 1'b1});
      else chk({coreFreq, pllMult, coreClkRun}, {i[1:0], mt[i], 1'b0});
      if (i == 0)
      begin
        step(psc_pkg::PLL_SETTLE_CYC + 100);
        chk({pllEnable, coreClkRun}, 2'b10);
        pllLock = 1'b1;
        wait_run(n);
        chk(16'(n), 16'h0003);
      end
      else if (i < 3) wait_run(n);
    end
    $display("frequency test done");
  endtask : t_freq
  task automatic t_periph;
    periphInUse = 9'h15a;
    step(2);
    chk(periphPowerEn, 9'h15a);
    periphInUse = 9'h0a5;
    step(2);
    chk(periphPowerEn, 9'h0a5);
    $display("peripheral test done");
  endtask : t_periph
  // first pass also asks for a frequency change in the same cycle: standby must win
  task automatic t_wake(input int k);
    int n;
    standbyReq = 1'b1;
    freqApply = (k == 0);
    freqSel = psc_pkg::FREQ_12M;
    step(1);
    standbyReq = 1'b0;
    freqApply = 1'b0;
    step(2);
    chk({inStandby, coreClkRun, crystalOscEnable, pllEnable, systemPowerEn, periphPowerEn}, {1'b1, 13'h0000});
    step(6);
    wk[k] = ~wk[k];
    oscReady = (k != 6); // last pass: oscillator slow to report ready
    n = 0;
    while (wakeEvent !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    chk({n < 10, inStandby, crystalOscEnable, systemPowerEn}, 4'b1011);
    if (n >= 10) end_sim();
    step(1);
    chk(wakeEvent, 1'b0);
    wk[k] = ~wk[k];
    if (k == 6)
    begin
      step(psc_pkg::OSC_SETTLE_CYC + 100);
      chk({crystalOscEnable, pllEnable, coreClkRun}, 3'b100);
      oscReady = 1'b1;
    end
    wait_run(n);
    chk({n >= ((k == 6) ? psc_pkg::PLL_SETTLE_CYC
        : psc_pkg::OSC_SETTLE_CYC + psc_pkg::PLL_SETTLE_CYC - 10), coreFreq},
        {1'b1, psc_pkg::FREQ_48M});
    $display("wake test %0d done", k);
  endtask : t_wake
  // main sequence: reset held 10 cycles first
  initial
  begin
    step(10);
    t_reset();
    t_freq();
    t_periph();
    for (int k = 0; k < 7; k++) t_wake(k);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
